// ===== rtl/bpl_link.v
// Sensor end of the biphase programming link with APB access
`timescale 1ns/1ns
`include "bpl_regs.vh"
module bpl_link #(
	parameter CW = 18,
	parameter [CW-1:0] HB_MIN = (`BPL_H_BIT_MIN_US * `BPL_CLK_MHZ * `BPL_H_HALF_MIN_PM + 999) / 1000,
	parameter [CW-1:0] HB_MAX = (`BPL_H_BIT_MAX_US * `BPL_CLK_MHZ * `BPL_H_HALF_MAX_PM) / 1000,
	parameter [CW-1:0] FB_MIN = `BPL_H_BIT_MIN_US * `BPL_CLK_MHZ,
	parameter [CW-1:0] FB_MAX = `BPL_H_BIT_MAX_US * `BPL_CLK_MHZ,
	parameter [CW-1:0] S_BIT = `BPL_S_BIT_US * `BPL_CLK_MHZ,
	parameter [CW-1:0] OVC_MIN = `BPL_OVC_MIN_US * `BPL_CLK_MHZ,
	parameter [CW-1:0] SWITCH = `BPL_SWITCH_US * `BPL_CLK_MHZ,
	parameter AW = 7
) (
	input wire CORE_CLK, // System clock
	input wire RST, // Synchronous reset
	input wire PSEL, // APB select
	input wire PENABLE, // APB enable
	input wire PWRITE, // APB direction
	input wire [7:0] PADDR, // APB byte address
	input wire [31:0] PWDATA, // APB write data
	output reg [31:0] PRDATA, // APB read data
	output wire PREADY, // APB ready
	output wire PSLVERR, // APB error
	input wire LINK_I, // Output pin level
	output reg LINK_O, // Output pin drive value
	output reg LINK_OE, // Output pin drive enable
	input wire SUP_I, // Supply modulation level
	input wire OVC_I, // Over-current comparator
	output wire PROG_MODE // Programming mode active
);
	localparam [CW-1:0] HALF = S_BIT >> 1;
	localparam [1:0] RX_IDLE = 2'd0, RX_BITS = 2'd1, RX_SKIP = 2'd2;
	localparam [2:0] TX_IDLE = 3'd0, TX_WAIT = 3'd1, TX_BITS = 3'd2, TX_ACK = 3'd3, TX_GAP = 3'd4;

	function [3:0] crc4;
		input [24:0] d;
		integer i;
		reg fb;
		begin
			crc4 = `BPL_CRC_INIT;
			for (i = 24; i >= 0; i = i - 1) begin
				fb = crc4[3] ^ d[i];
				crc4 = {crc4[2:0], 1'b0} ^ (fb ? `BPL_CRC_POLY : 4'h0);
			end
		end
	endfunction

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	reg [2:0] lk_s_q, sp_s_q, ov_s_q;
	reg lk_f_q, sp_f_q, ov_f_q;
	always @(posedge CORE_CLK) begin
		if (RST) begin
			lk_s_q <= 3'h7;
			sp_s_q <= 3'h7;
			ov_s_q <= 3'h0;
			lk_f_q <= 1'b1;
			sp_f_q <= 1'b1;
			ov_f_q <= 1'b0;
		end else begin
			lk_s_q <= {lk_s_q[1:0], LINK_I};
			sp_s_q <= {sp_s_q[1:0], SUP_I};
			ov_s_q <= {ov_s_q[1:0], OVC_I};
			if (lk_s_q[1] == lk_s_q[2]) lk_f_q <= lk_s_q[2];
			if (sp_s_q[1] == sp_s_q[2]) sp_f_q <= sp_s_q[2];
			if (ov_s_q[1] == ov_s_q[2]) ov_f_q <= ov_s_q[2];
		end
	end

	// ----------------------------------------
	// Registers and memory
	// ----------------------------------------
	reg [1:0] ctrl_q;
	reg [3:0] err_q;
	reg [AW-1:0] madr_q;
	reg [1:0] base_q;
	reg prog_q;
	reg [15:0] mem [0:(1<<AW)-1];
	wire setup = PSEL & ~PENABLE;
	wire acc = PSEL & PENABLE;
	wire hit = (PADDR == `BPL_A_CTRL) | (PADDR == `BPL_A_STAT) | (PADDR == `BPL_A_ERR) |
		(PADDR == `BPL_A_MADR) | (PADDR == `BPL_A_MDAT);
	wire wr = acc & PWRITE & hit;
	assign PREADY = 1'b1;
	assign PSLVERR = acc & ~hit;
	assign PROG_MODE = prog_q | ctrl_q[`BPL_CTRL_PROG];

	// ----------------------------------------
	// Over-current entry into programming mode
	// ----------------------------------------
	reg [CW-1:0] ov_cnt_q, sw_cnt_q;
	reg ov_p_q, sw_run_q;
	always @(posedge CORE_CLK) begin
		if (RST) begin
			ov_cnt_q <= {CW{1'b0}};
			sw_cnt_q <= {CW{1'b0}};
			ov_p_q <= 1'b0;
			sw_run_q <= 1'b0;
			prog_q <= 1'b0;
		end else begin
			ov_p_q <= ov_f_q;
			if (ov_f_q & ~ov_p_q) ov_cnt_q <= {CW{1'b0}};
			else if (ov_f_q && ov_cnt_q != OVC_MIN) ov_cnt_q <= ov_cnt_q + 1'b1;
			if (~ov_f_q & ov_p_q & (ov_cnt_q == OVC_MIN) & ~prog_q) begin
				sw_run_q <= 1'b1;
				sw_cnt_q <= {CW{1'b0}};
			end else if (sw_run_q) begin
				// Telegrams stay ignored until the switch time has run out
				if (sw_cnt_q == SWITCH - 1'b1) begin
					sw_run_q <= 1'b0;
					prog_q <= 1'b1;
				end
				sw_cnt_q <= sw_cnt_q + 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Biphase receiver
	// ----------------------------------------
	reg [1:0] rx_st_q;
	reg [CW-1:0] rx_cnt_q;
	reg [29:0] rx_sh_q;
	reg [4:0] rx_n_q;
	reg rx_half_q, rx_p_q, fr_done_q, frm_err_q;
	reg [2:0] tx_st_q;
	wire rx_lvl = ctrl_q[`BPL_CTRL_SUP] ? sp_f_q : lk_f_q;
	wire edge_r = rx_lvl ^ rx_p_q;
	wire is_half = (rx_cnt_q >= HB_MIN) & (rx_cnt_q <= HB_MAX);
	wire is_full = (rx_cnt_q >= FB_MIN) & (rx_cnt_q <= FB_MAX);
	always @(posedge CORE_CLK) begin
		if (RST) begin
			rx_st_q <= RX_IDLE;
			rx_cnt_q <= {CW{1'b0}};
			rx_sh_q <= 30'h0000_0000;
			rx_n_q <= 5'h00;
			rx_half_q <= 1'b0;
			rx_p_q <= 1'b1;
			fr_done_q <= 1'b0;
			frm_err_q <= 1'b0;
		end else begin
			rx_p_q <= rx_lvl;
			fr_done_q <= 1'b0;
			frm_err_q <= 1'b0;
			if (edge_r) rx_cnt_q <= {CW{1'b0}};
			else if (rx_cnt_q != FB_MAX) rx_cnt_q <= rx_cnt_q + 1'b1;
			case (rx_st_q)
				RX_IDLE: begin
					if (edge_r & PROG_MODE & (tx_st_q == TX_IDLE)) begin
						rx_st_q <= RX_BITS;
						rx_n_q <= 5'h00;
						rx_half_q <= 1'b0;
					end
				end
				RX_BITS: begin
					if (edge_r) begin
						if (is_half & rx_half_q) begin
							rx_sh_q <= {rx_sh_q[28:0], 1'b1};
							rx_n_q <= rx_n_q + 1'b1;
							rx_half_q <= 1'b0;
						end else if (is_half) begin
							rx_half_q <= 1'b1;
						end else if (is_full & ~rx_half_q) begin
							rx_sh_q <= {rx_sh_q[28:0], 1'b0};
							rx_n_q <= rx_n_q + 1'b1;
						end else begin
							frm_err_q <= 1'b1;
							rx_st_q <= RX_SKIP;
						end
						if (rx_n_q == `BPL_NB_WRITE) begin
							frm_err_q <= 1'b1;
							rx_st_q <= RX_SKIP;
						end
					end else if (rx_cnt_q == FB_MAX) begin
						// Quiet for longer than a bit ends the frame
						frm_err_q <= rx_half_q;
						fr_done_q <= ~rx_half_q;
						rx_st_q <= RX_IDLE;
					end
				end
				RX_SKIP: begin
					if (~edge_r && rx_cnt_q == FB_MAX) rx_st_q <= RX_IDLE;
				end
				default: rx_st_q <= RX_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Telegram decode
	// ----------------------------------------
	wire is_rd = rx_n_q == `BPL_NB_READ;
	wire is_wr = rx_n_q == `BPL_NB_WRITE;
	wire [9:0] hdr = is_rd ? rx_sh_q[9:0] : rx_sh_q[29:20];
	wire [2:0] cmd_field = hdr[8:6];
	wire [4:0] ofs = hdr[5:1];
	wire [15:0] payload_field = rx_sh_q[19:4];
	wire par_ok = ^hdr[8:0];
	wire crc_ok = crc4(rx_sh_q[28:4]) == rx_sh_q[3:0];
	wire good = fr_done_q & ~hdr[9] & par_ok;
	wire [AW-1:0] eff = {base_q, ofs};
	wire do_rd = good & is_rd & (cmd_field == `BPL_CMD_READ);
	wire do_wr = good & is_wr & crc_ok & (cmd_field == `BPL_CMD_WRITE);
	wire do_sb = good & is_wr & crc_ok & (cmd_field == `BPL_CMD_SETB);
	// Anything else in a sound frame is a command error and stays silent
	wire e_cmd = good & (is_rd | (is_wr & crc_ok)) & ~do_rd & ~do_wr & ~do_sb;
	wire e_par = fr_done_q & (is_rd | is_wr) & ~hdr[9] & ~par_ok;
	wire e_crc = good & is_wr & ~crc_ok;
	wire e_frm = frm_err_q | (fr_done_q & ((~is_rd & ~is_wr) | hdr[9]));
	wire [3:0] e_set = {e_frm, e_cmd, e_crc, e_par};
	wire apb_mw = wr & (PADDR == `BPL_A_MDAT);

	always @(posedge CORE_CLK) begin
		if (do_wr) mem[eff] <= payload_field;
		else if (apb_mw) mem[madr_q] <= PWDATA[15:0];
	end

	always @(posedge CORE_CLK) begin
		if (RST) begin
			base_q <= 2'h0;
			ctrl_q <= 2'h0;
			err_q <= 4'h0;
			madr_q <= {AW{1'b0}};
		end else begin
			if (do_sb) base_q <= payload_field[1:0];
			if (wr & (PADDR == `BPL_A_CTRL)) ctrl_q <= PWDATA[1:0];
			if (wr & (PADDR == `BPL_A_MADR)) madr_q <= PWDATA[AW-1:0];
			// New errors win over a clear in the same cycle
			if (wr & (PADDR == `BPL_A_ERR)) err_q <= (err_q & ~PWDATA[3:0]) | e_set;
			else err_q <= err_q | e_set;
		end
	end

	always @(posedge CORE_CLK) begin
		if (RST) PRDATA <= 32'h0000_0000;
		else if (setup & ~PWRITE) begin
			case (PADDR)
				`BPL_A_CTRL: PRDATA <= {30'h0000_0000, ctrl_q};
				`BPL_A_STAT: PRDATA <= {26'h000_0000, tx_st_q != TX_IDLE, rx_st_q != RX_IDLE, base_q, prog_q,
					PROG_MODE};
				`BPL_A_ERR: PRDATA <= {28'h000_0000, err_q};
				`BPL_A_MADR: PRDATA <= {{(32-AW){1'b0}}, madr_q};
				`BPL_A_MDAT: PRDATA <= {16'h0000, mem[madr_q]};
				default: PRDATA <= 32'h0000_0000;
			endcase
		end
	end

	// ----------------------------------------
	// Biphase transmitter
	// ----------------------------------------
	reg [CW-1:0] tx_cnt_q;
	reg [20:0] tx_sh_q;
	reg [4:0] tx_n_q;
	reg tx_ack_q;
	always @(posedge CORE_CLK) begin
		if (RST) begin
			tx_st_q <= TX_IDLE;
			tx_cnt_q <= {CW{1'b0}};
			tx_sh_q <= 21'h00_0000;
			tx_n_q <= 5'h00;
			tx_ack_q <= 1'b0;
			LINK_O <= 1'b1;
			LINK_OE <= 1'b0;
		end else begin
			case (tx_st_q)
				TX_IDLE: begin
					tx_cnt_q <= {CW{1'b0}};
					LINK_O <= 1'b1;
					LINK_OE <= 1'b0;
					if (do_rd | do_wr | do_sb) begin
						tx_st_q <= TX_WAIT;
						tx_ack_q <= ~do_rd;
						tx_n_q <= 5'h00;
						tx_sh_q <= {1'b0, mem[eff], crc4({9'h000, mem[eff]})};
					end
				end
				TX_WAIT: begin
					// Frame end was seen one bit late, so the reply starts about two bits after it
					tx_cnt_q <= tx_cnt_q + 1'b1;
					if (tx_cnt_q == S_BIT - 1'b1) begin
						tx_n_q <= tx_n_q + 1'b1;
						tx_cnt_q <= {CW{1'b0}};
						if (tx_n_q == `BPL_RESP_BITS - 1) begin
							tx_st_q <= tx_ack_q ? TX_ACK : TX_BITS;
							tx_n_q <= tx_ack_q ? 5'h03 : `BPL_NB_RESP;
							LINK_OE <= 1'b1;
							// Data opens with a falling edge, an acknowledge with a space
							LINK_O <= tx_ack_q;
						end
					end
				end
				TX_BITS: begin
					tx_cnt_q <= tx_cnt_q + 1'b1;
					if (tx_cnt_q == HALF - 1'b1 && tx_sh_q[20]) LINK_O <= ~LINK_O;
					if (tx_cnt_q == S_BIT - 1'b1) begin
						tx_cnt_q <= {CW{1'b0}};
						LINK_O <= ~LINK_O;
						tx_sh_q <= {tx_sh_q[19:0], 1'b0};
						tx_n_q <= tx_n_q - 1'b1;
						if (tx_n_q == 5'h01) begin
							tx_st_q <= TX_GAP;
							tx_n_q <= 5'h00;
							// Release on the last boundary so no short pulse follows the frame
							LINK_O <= 1'b1;
							LINK_OE <= 1'b0;
						end
					end
				end
				TX_ACK: begin
					// Space, low pulse, space, one bit each
					tx_cnt_q <= tx_cnt_q + 1'b1;
					if (tx_cnt_q == S_BIT - 1'b1) begin
						tx_cnt_q <= {CW{1'b0}};
						tx_n_q <= tx_n_q - 1'b1;
						// Levels switch on the boundary itself, so each part lasts a full bit
						LINK_O <= tx_n_q != 5'h03;
						if (tx_n_q == 5'h01) begin
							tx_st_q <= TX_GAP;
							tx_n_q <= 5'h00;
							LINK_O <= 1'b1;
							LINK_OE <= 1'b0;
						end
					end
				end
				TX_GAP: begin
					LINK_OE <= 1'b0;
					LINK_O <= 1'b1;
					tx_cnt_q <= tx_cnt_q + 1'b1;
					if (tx_cnt_q == S_BIT - 1'b1) begin
						tx_cnt_q <= {CW{1'b0}};
						tx_n_q <= tx_n_q + 1'b1;
						if (tx_n_q == `BPL_S_IFS_BITS - 1) tx_st_q <= TX_IDLE;
					end
				end
				default: tx_st_q <= TX_IDLE;
			endcase
		end
	end
endmodule // bpl_link

// ===== rtl/bpl_regs.vh
// Constants of the biphase programming link
`ifndef BPL_REGS_VH
`define BPL_REGS_VH
// ----------------------------------------
// Timing
// ----------------------------------------
`define BPL_CLK_MHZ 50
`define BPL_H_BIT_MIN_US 972
`define BPL_H_BIT_MAX_US 1075
`define BPL_H_HALF_MIN_PM 450
`define BPL_H_HALF_MAX_PM 550
`define BPL_S_BIT_US 1024
`define BPL_OVC_MIN_US 1000
`define BPL_SWITCH_US 4000
`define BPL_RESP_BITS 1
`define BPL_S_IFS_BITS 2
// ----------------------------------------
// Frame
// ----------------------------------------
`define BPL_CMD_READ 3'h1
`define BPL_CMD_SETB 3'h3
`define BPL_CMD_WRITE 3'h6
`define BPL_NB_READ 5'h0A
`define BPL_NB_WRITE 5'h1E
`define BPL_NB_RESP 5'h15
`define BPL_CRC_INIT 4'h0
`define BPL_CRC_POLY 4'h3
// ----------------------------------------
// Register map
// ----------------------------------------
`define BPL_A_CTRL 8'h00
`define BPL_A_STAT 8'h04
`define BPL_A_ERR 8'h08
`define BPL_A_MADR 8'h0C
`define BPL_A_MDAT 8'h10
`define BPL_CTRL_SUP 0
`define BPL_CTRL_PROG 1
`define BPL_ERR_PAR 0
`define BPL_ERR_CRC 1
`define BPL_ERR_CMD 2
`define BPL_ERR_FRM 3
`endif

// ===== tb/bpl_link_assertions.sv
// Port-level checker for the biphase link
`timescale 1ns/1ns
module bpl_link_chk #(
	parameter CW = 18,
	parameter [CW-1:0] S_BIT = 51200,
	parameter [CW-1:0] SWITCH = 200000
) (
	input wire CORE_CLK, // Clock
	input wire RST, // Reset
	input wire PSEL, // APB
	input wire PENABLE, // APB
	input wire PWRITE, // APB
	input wire [7:0] PADDR, // APB
	input wire [31:0] PWDATA, // APB
	input wire [31:0] PRDATA, // APB
	input wire PREADY, // APB
	input wire PSLVERR, // APB
	input wire LINK_I, // Pin level
	input wire LINK_O, // Pin drive
	input wire LINK_OE, // Pin enable
	input wire SUP_I, // Supply level
	input wire OVC_I, // Over-current
	input wire PROG_MODE // Mode
);
	logic o_q, oe_q, li_q, su_q;
	logic [23:0] run_q, len_q, idle_q, in_q, ovc_q;
	// idle_q, in_q and ovc_q saturate, so long idle spans never wrap
	always @(posedge CORE_CLK) begin
		if (RST) begin
			run_q <= 24'h00_0000;
			len_q <= 24'h00_0000;
			idle_q <= 24'hFF_FFFF;
			in_q <= 24'hFF_FFFF;
			ovc_q <= 24'hFF_FFFF;
		end else begin
			run_q <= (LINK_O != o_q || LINK_OE != oe_q) ? 24'h00_0001 : run_q + 24'h00_0001;
			len_q <= LINK_OE ? len_q + 24'h00_0001 : 24'h00_0000;
			idle_q <= LINK_OE ? 24'h00_0000 : idle_q + {23'h00_0000, ~&idle_q};
			in_q <= (LINK_I != li_q || SUP_I != su_q) ? 24'h00_0001 : in_q + {23'h00_0000, ~&in_q};
			ovc_q <= OVC_I ? 24'h00_0000 : ovc_q + {23'h00_0000, ~&ovc_q};
		end
		o_q <= LINK_O;
		oe_q <= LINK_OE;
		li_q <= LINK_I;
		su_q <= SUP_I;
	end
	default clocking cb @(posedge CORE_CLK);
	endclocking
	default disable iff (RST);
	chk_edge_grid: assert property (LINK_OE && oe_q && LINK_O != o_q |-> run_q == S_BIT / 2 || run_q == S_BIT)
		else $error("sensor edge off the bit grid");
	chk_reply_len: assert property ($fell(LINK_OE) |-> len_q == 3 * S_BIT || len_q == 21 * S_BIT)
		else $error("reply length wrong");
	chk_ack_end: assert property ($fell(LINK_OE) && len_q == 3 * S_BIT |-> o_q)
		else $error("ack not closed by a space");
	chk_ack_space: assert property ($rose(LINK_OE) && LINK_O |-> (LINK_OE && LINK_O) [*8])
		else $error("space before ack too short");
	chk_sensor_gap: assert property ($rose(LINK_OE) |-> idle_q >= 2 * S_BIT)
		else $error("sensor gap too short");
	chk_resp_delay: assert property ($rose(LINK_OE) |-> in_q >= S_BIT && in_q <= 5 * S_BIT)
		else $error("response delay out of range");
	chk_prog_gate: assert property ($rose(LINK_OE) |-> PROG_MODE)
		else $error("reply outside programming mode");
	chk_switch_time: assert property ($rose(PROG_MODE) |-> ovc_q >= SWITCH && ovc_q <= SWITCH + 8)
		else $error("mode switch time wrong");
	chk_err_phase: assert property (PSLVERR |-> PSEL && PENABLE && PREADY)
		else $error("slave error outside access");
endmodule // bpl_link_chk
bind bpl_link bpl_link_chk #(.CW(CW), .S_BIT(S_BIT), .SWITCH(SWITCH)) chk_u (.CORE_CLK(CORE_CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
	.PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_I(LINK_I), .LINK_O(LINK_O), .LINK_OE(LINK_OE), .SUP_I(SUP_I),
	.OVC_I(OVC_I), .PROG_MODE(PROG_MODE));

// ===== tb/bpl_host.sv
// Programming host model sending biphase telegrams
`timescale 1ns/1ns
module bpl_host #(parameter HALF = 32) (
	input wire clk, // Clock
	input wire oe, // Sensor drives pin
	output logic drv // Host level, 1 is released
);
	initial drv = 1'b1;
	// Let go while the sensor answers so the pull-up wins
	always @(posedge clk) begin
		if (oe) begin
			drv <= 1'b1;
		end
	end
	task automatic send(input logic [29:0] fr, input int n);
		for (int i = n - 1; i >= 0; i--) begin
			drv <= ~drv;
			repeat (HALF) @(posedge clk);
			if (fr[i]) begin
				drv <= ~drv;
			end
			repeat (HALF) @(posedge clk);
		end
		drv <= ~drv;
	endtask
endmodule // bpl_host

// ===== tb/tb_top.sv
// Bench: APB master, host model and reference model
`timescale 1ns/1ns
module tb_top;
	localparam int SB = 64;
	logic CORE_CLK = 1'b0, RST = 1'b1, PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0, OVC_I = 1'b0, er;
	logic [7:0] PADDR = 8'h00;
	logic [31:0] PWDATA = 32'h0000_0000, rd;
	wire [31:0] PRDATA;
	wire PREADY, PSLVERR, LINK_O, LINK_OE, PROG_MODE, hl;
	logic sel = 1'b0;
	// Host on the supply pin: the output pin then only carries replies
	wire pin = LINK_OE ? LINK_O : (sel ? 1'b1 : hl);
	wire sup = sel ? hl : 1'b1;
	int failures = 0, checked = 0, seed = 63206, pm = 0, base = 0, a, b, d;
	int mem [128];
	always #10 CORE_CLK = ~CORE_CLK;
	// Short bit time keeps the run small; windows keep near the same ratios, in steps of 4 cycles
	localparam logic [17:0] P_SB = 18'h0_0040, P_HMIN = 18'h0_001C, P_HMAX = 18'h0_0024, P_FMIN = 18'h0_003C;
	localparam logic [17:0] P_FMAX = 18'h0_0044, P_OVC = 18'h0_0010, P_SW = 18'h0_0028;
	bpl_link #(.S_BIT(P_SB), .HB_MIN(P_HMIN), .HB_MAX(P_HMAX), .FB_MIN(P_FMIN), .FB_MAX(P_FMAX), .OVC_MIN(P_OVC),
		.SWITCH(P_SW)) dut_u (.CORE_CLK(CORE_CLK), .RST(RST),
		.PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .LINK_I(pin), .LINK_O(LINK_O), .LINK_OE(LINK_OE), .SUP_I(sup),
		.OVC_I(OVC_I), .PROG_MODE(PROG_MODE));
	bpl_host host_u (.clk(CORE_CLK), .oe(LINK_OE), .drv(hl));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checked++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge CORE_CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= ad;
		PWDATA <= wd;
		@(posedge CORE_CLK);
		PENABLE <= 1'b1;
		@(posedge CORE_CLK);
		while (PREADY !== 1'b1) @(posedge CORE_CLK);
		rd = PRDATA;
		er = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] ad, input logic [31:0] exp, input string what);
		apb(1'b0, ad, 32'h0000_0000);
		chk(rd, exp, what);
	endtask
	function automatic logic [3:0] crc4(input logic [24:0] v, input int n);
		logic [3:0] c;
		c = 4'h0;
		for (int i = n - 1; i >= 0; i--) c = {c[2:0], 1'b0} ^ ((c[3] ^ v[i]) ? 4'h3 : 4'h0);
		return c;
	endfunction
	function automatic logic [29:0] frame(input int cmd, f, adr, dat, err);
		logic [8:0] h;
		h = {cmd[2:0], adr[4:0], ~^{cmd[2:0], adr[4:0]} ^ err[0]};
		if (f == 0) return {21'h00_0000, h};
		return {1'b0, h, dat[15:0], crc4({h, dat[15:0]}, 25) ^ {3'h0, err[1]}};
	endfunction
	task automatic tel(input int cmd, f, adr, dat, err);
		logic [29:0] fr;
		logic [31:0] r;
		int ex, n, idx;
		ex = (pm == 0 || err != 0) ? 0 : (f != 0) ? ((cmd == 6 || cmd == 3) ? 1 : 0) : (cmd == 1 ? 2 : 0);
		idx = base * 32 + adr;
		fr = frame(cmd, f, adr, dat, err);
		// Silent write frames must end high, else the final release looks like a new frame
		while (f != 0 && ex == 0 && ^fr == 1'b0) begin
			dat++;
			fr = frame(cmd, f, adr, dat, err);
		end
		@(posedge CORE_CLK);
		host_u.send(fr, f != 0 ? 30 : 10);
		n = 0;
		while (LINK_OE !== 1'b1 && n < 400) begin
			@(negedge CORE_CLK);
			n++;
		end
		chk(n < 400, ex != 0, "reply present");
		if (ex != 0) chk(n >= SB && n <= 5 * SB, 1, "reply delay");
		r = 32'h0000_0000;
		for (int i = 0; i < (ex == 1 ? 4 : 0); i++) begin
			repeat (i == 0 ? SB / 2 : SB) @(negedge CORE_CLK);
			r[3 - i] = (i == 3) ? LINK_OE : pin;
		end
		if (ex == 1) chk(r, 4'b1010, "ack shape");
		for (int i = 20; i >= 0 && ex == 2; i--) begin
			repeat (SB / 4) @(negedge CORE_CLK);
			r[i] = pin;
			repeat (SB / 2) @(negedge CORE_CLK);
			r[i] = r[i] ^ pin;
			repeat (SB / 4) @(negedge CORE_CLK);
		end
		if (ex == 2) chk(r, {1'b0, mem[idx][15:0], crc4(mem[idx][15:0], 16)}, "read reply");
		if (ex == 1 && cmd == 6) mem[idx] = dat;
		if (ex == 1 && cmd == 3) base = dat % 4;
		repeat (6 * SB) @(negedge CORE_CLK);
	endtask
	task automatic print_verdict();
		$display("Comparisons %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge CORE_CLK);
		RST <= 1'b0;
		repeat (4) @(posedge CORE_CLK);
		rdchk(8'h00, 0, "control");
		rdchk(8'h04, 0, "status");
		rdchk(8'h08, 0, "errors");
		apb(1'b0, 8'h40, 32'h0000_0000);
		chk(er, 1, "unmapped");
		tel(6, 1, 5, 32'h0000_1234, 0);
		OVC_I <= 1'b1;
		repeat (20) @(posedge CORE_CLK);
		OVC_I <= 1'b0;
		repeat (30) @(negedge CORE_CLK);
		chk(PROG_MODE, 0, "early mode");
		repeat (20) @(negedge CORE_CLK);
		chk(PROG_MODE, 1, "prog mode");
		pm = 1;
		for (int i = 0; i < 3; i++) begin
			b = $random(seed) & 3;
			a = $random(seed) & 31;
			d = $random(seed) & 32'h0000_FFFF;
			tel(3, 1, a ^ 9, (d & 32'h0000_FFFC) | b, 0);
			rdchk(8'h04, b * 4 + 3, "base");
			tel(6, 1, a, d, 0);
			tel(1, 0, a, 0, 0);
		end
		for (int c = 0; c < 16; c++) tel(c / 2, c % 2, a, d, 0);
		rdchk(8'h08, 4, "cmd error");
		apb(1'b1, 8'h08, 32'h0000_000F);
		tel(6, 1, a, d, 1);
		tel(6, 1, a, d, 2);
		tel(3, 1, a, d, 2);
		rdchk(8'h08, 3, "link errors");
		// Supply route: host modulates the supply, replies still come on the output pin
		apb(1'b1, 8'h00, 32'h0000_0001);
		rdchk(8'h00, 1, "supply route");
		sel <= 1'b1;
		tel(6, 1, a, d ^ 32'h0000_5A5A, 0);
		tel(1, 0, a, 0, 0);
		sel <= 1'b0;
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h0C, base * 32 + a);
		rdchk(8'h10, mem[base * 32 + a], "memory");
		print_verdict();
	end
	initial begin
		repeat (90000) @(posedge CORE_CLK);
		failures++;
		print_verdict();
	end
endmodule // tb_top
